// *** flash_block_guard.v ***
// per-block protect and lock state
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.vh"

module flash_block_guard (
  input wire clk, // system clock
  input wire rst_n, // async reset, low
  input wire wp_n_s, // synced write-protect pin
  input wire guard_we, // apply a protection command
  input wire [1:0] guard_op, // 0 protect, 1 unprotect, 2 lock
  input wire [`BLK_IDX_W-1:0] guard_blk, // target block
  input wire [`BLK_IDX_W-1:0] query_blk, // block being looked up
  output wire query_prot, // effective protection
  output wire query_lock // lock status
);

  reg [`NUM_BLOCKS-1:0] prot_q;
  reg [`NUM_BLOCKS-1:0] lock_q;

  // ==========================================
  // state per block
  genvar i;
  generate
    for (i = 0; i < `NUM_BLOCKS; i = i + 1) begin : g_blk
      wire hit = guard_we && (guard_blk == i);
      // locked blocks frozen only while wp low
      wire can_change = wp_n_s || !lock_q[i];
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prot_q[i] <= 1'b1;
          lock_q[i] <= 1'b0;
        end else if (hit) begin
          if (guard_op == 2'd2) begin
            lock_q[i] <= 1'b1;
          end else if (can_change) begin
            prot_q[i] <= (guard_op == 2'd0);
          end
        end
      end
    end
  endgenerate

  // locked and wp low means protected regardless of bit
  assign query_prot = prot_q[query_blk] || (!wp_n_s && lock_q[query_blk]);
  assign query_lock = lock_q[query_blk];

endmodule
`default_nettype wire

// *** flash_cmd_defines.vh ***
// constants for the flash command interface
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// ==========================================
// command codes
`define CMD_SETUP 8'h60
`define CMD_GUARD 8'h01
`define CMD_UNGUARD 8'hd0
`define CMD_FREEZE 8'h2f
`define CMD_CFG_CONFIRM 8'h03
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'hd0
`define CMD_READ_ARRAY 8'hff
`define CMD_STATUS_READ 8'h70
`define CMD_SIGNATURE_READ 8'h90
`define CMD_QUERY_READ 8'h98
`define CMD_PROGRAM 8'h40
`define CMD_CLEAR_STATUS 8'h50
`define CMD_OTP_PROGRAM 8'hc0

// ==========================================
// geometry
`define NUM_BLOCKS 64
`define BLK_IDX_W 6
`define BLK_SHIFT 16
`define BANK_BIT 21
`define SEC_BLK_TOP 6'h3f
`define SEC_BLK_BOT 6'h00

// ==========================================
// signature / protection register words
`define SIG_PROT_LOC 8'h02
`define SIG_CFG_LOC 8'h05
`define PR_LOCK_ADDR 8'h80
`define PR_UID_FIRST 8'h81
`define PR_UID_LAST 8'h84
`define PR_OTP_FIRST 8'h85
`define PR_OTP_LAST 8'h88
`define PR_LOCK_OTP_BIT 1
`define PR_LOCK_SEC_BIT 2

// ==========================================
// configuration register fields and reset value
`define CFG_RESET 16'h81cf
`define CFG_MODE_BIT 15
`define CFG_INV_BIT 14
`define CFG_LAT_HI 13
`define CFG_LAT_LO 11
`define CFG_PD_BIT 10
`define CFG_WAIT_BIT 8
`define CFG_ORDER_BIT 7
`define CFG_EDGE_BIT 6
`define CFG_WRAP_BIT 3
`define CFG_LEN_HI 2
`define CFG_LEN_LO 0
`define LAT_MIN 3'h2
`define LAT_MAX 3'h5
`define LEN_4 3'h1
`define LEN_8 3'h2
`define LEN_CONT 3'h7

// ==========================================
// status bits
`define STAT_READY 7
`define STAT_ERASE_ERR 5
`define STAT_PROG_ERR 4
`define STAT_SUSP 2
`define STAT_GUARD_ERR 1

// ==========================================
// timing
`define PROG_TIME_US 10
`define CLK_MHZ 40
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define PROG_CNT_W 9

`endif

// *** flash_cmd_if.v ***
// command interface: suspend, block protection, otp register, config register
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.vh"

// Notes on behaviour
// - suspend B0h accepted only during program
// - suspended flag set only when actually suspended
// - suspended accepts resume and read commands only
// - resume D0h clears suspended and ready flags
// - protect/unprotect/lock are 60h then code
// - bad second code sets status bits 4,5
// - all blocks protected at power-up
// - wp high ignores lock status
// - wp low locked blocks stay protected
// - lock status cleared at power-up
// - signature read: bit0 protected, bit1 locked
// - 128-bit register, unique id plus otp
// - lock bit1 freezes otp, bit2 secures block
// - security block top or bottom range
// - words 80h-88h return lock, id, otp
// - config written by 60h then 03h
// - config resets to page, linear, rising
// - page read selects word by two lsbs
// - invert pin direction per config bits
// - latency codes 2..5 valid, others reserved
// - wait timing, order, edge bits
// - wrap and burst length, continuous needs linear

module flash_cmd_if #(
  parameter TOP_VARIANT = 1'b1, // 1 top parameter, 0 bottom
  parameter [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
) (
  input wire clk, // system clock 40 MHz
  input wire rst_n, // async reset, low
  input wire reset_powerdown_n, // reset/power-down pin, low active
  input wire wp_n, // write-protect pin
  input wire latch_n, // latch-enable pin, low active
  input wire write_n, // write-enable pin, low active
  input wire [15:0] mux_addr_data, // multiplexed address/data in
  input wire [5:0] upper_addr, // upper address inputs
  input wire bus_invert_in, // invert pin input level
  output reg [15:0] read_data_q, // read data out
  output reg bus_invert_out_q, // invert pin output level
  output reg bus_invert_oe_q, // invert pin output enable
  output reg [15:0] read_configuration_q, // configuration register
  output reg [7:0] status_q, // status register
  output reg [1:0] latency_q, // latency 2..5 as 0..3
  output reg latency_bad_q, // latency code reserved
  output reg length_bad_q, // burst length invalid
  output reg sec_block_prot_q, // security block locked
  output reg [1:0] page_word_q // page buffer word select
);

  // ==========================================
  // pin synchronisers
  reg [1:0] wp_sync_q;
  reg [1:0] we_sync_q;
  reg [1:0] le_sync_q;
  reg [1:0] pin_rst_sync_q;
  reg [1:0] inv_sync_q;
  reg [15:0] adq_m_q;
  reg [15:0] adq_q;
  reg [5:0] up_m_q;
  reg [5:0] up_q;
  reg we_prev_q;
  reg le_prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_sync_q <= 2'b00;
      we_sync_q <= 2'b11;
      le_sync_q <= 2'b11;
      pin_rst_sync_q <= 2'b00;
      inv_sync_q <= 2'b00;
      adq_m_q <= 16'h0000;
      adq_q <= 16'h0000;
      up_m_q <= 6'h00;
      up_q <= 6'h00;
      we_prev_q <= 1'b1;
      le_prev_q <= 1'b1;
    end else begin
      wp_sync_q <= {wp_sync_q[0], wp_n};
      we_sync_q <= {we_sync_q[0], write_n};
      le_sync_q <= {le_sync_q[0], latch_n};
      pin_rst_sync_q <= {pin_rst_sync_q[0], reset_powerdown_n};
      inv_sync_q <= {inv_sync_q[0], bus_invert_in};
      adq_m_q <= mux_addr_data;
      adq_q <= adq_m_q;
      up_m_q <= upper_addr;
      up_q <= up_m_q;
      we_prev_q <= we_sync_q[1];
      le_prev_q <= le_sync_q[1];
    end
  end

  wire wp_s = wp_sync_q[1];
  wire pin_rst_low = !pin_rst_sync_q[1];
  // write taken on rising edge of write-enable
  wire wr_stb = !we_prev_q && we_sync_q[1];
  // address latched on rising edge of latch-enable
  wire le_rise = !le_prev_q && le_sync_q[1];

  // ==========================================
  // latched address and inverted data
  reg [21:0] addr_q;
  wire inv_active = read_configuration_q[`CFG_INV_BIT];
  // data inverted when config invert bit set and pin input active; address never
  wire [15:0] wdata = (inv_active && inv_sync_q[1]) ? ~adq_q : adq_q;
  wire [7:0] code = wdata[7:0];

  // ==========================================
  // command state machine
  localparam S_READ = 3'd0;
  localparam S_SETUP = 3'd1;
  localparam S_PROG_DATA = 3'd2;
  localparam S_PROGRAMMING = 3'd3;
  localparam S_SUSPENDED = 3'd4;
  localparam S_OTP_DATA = 3'd5;

  localparam RM_ARRAY = 2'd0;
  localparam RM_STATUS = 2'd1;
  localparam RM_SIG = 2'd2;
  // program time of 400 cycles loads as 399 and fits the counter width
  localparam [`PROG_CNT_W-1:0] PROG_LOAD = `PROG_CYCLES - 1;

  reg [2:0] state_q;
  reg [1:0] rmode_q;
  reg [`PROG_CNT_W-1:0] prog_cnt_q;
  reg prog_bank_q;
  reg [15:0] lock_word_q;
  reg [63:0] otp_q;

  wire [`BLK_IDX_W-1:0] cur_blk = addr_q[`BLK_SHIFT+`BLK_IDX_W-1:`BLK_SHIFT];
  wire blk_prot;
  wire blk_lock;
  reg guard_we;
  reg [1:0] guard_op;

  flash_block_guard u_guard (
    .clk(clk),
    .rst_n(rst_n),
    .wp_n_s(wp_s),
    .guard_we(guard_we),
    .guard_op(guard_op),
    .guard_blk(cur_blk),
    .query_blk(cur_blk),
    .query_prot(blk_prot),
    .query_lock(blk_lock)
  );

  wire sec_hit = TOP_VARIANT ? (cur_blk == `SEC_BLK_TOP) : (cur_blk == `SEC_BLK_BOT);
  // lock word ships as ones; programming bit 2 to zero locks
  wire sec_locked = !lock_word_q[`PR_LOCK_SEC_BIT];
  wire prog_refused = blk_prot || (sec_hit && sec_locked);
  wire in_prog_bank = (addr_q[`BANK_BIT] == prog_bank_q);
  wire [7:0] pr_addr = addr_q[7:0];
  wire pr_is_otp = (pr_addr >= `PR_OTP_FIRST) && (pr_addr <= `PR_OTP_LAST);
  wire [1:0] pr_word = pr_addr[1:0] - 2'd1;

  always @* begin
    guard_we = 1'b0;
    guard_op = 2'd0;
    if (wr_stb && state_q == S_SETUP && !pin_rst_low) begin
      guard_we = (code == `CMD_GUARD) || (code == `CMD_UNGUARD) || (code == `CMD_FREEZE);
      guard_op = (code == `CMD_UNGUARD) ? 2'd1 : ((code == `CMD_FREEZE) ? 2'd2 : 2'd0);
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_READ;
      rmode_q <= RM_ARRAY;
      addr_q <= 22'h000000;
      status_q <= 8'h80;
      prog_cnt_q <= {`PROG_CNT_W{1'b0}};
      prog_bank_q <= 1'b0;
      lock_word_q <= 16'hffff;
      otp_q <= {64{1'b1}};
      read_configuration_q <= `CFG_RESET;
    end else if (pin_rst_low) begin
      // pin reset aborts a running or suspended program
      state_q <= S_READ;
      rmode_q <= RM_ARRAY;
      status_q <= 8'h80;
      read_configuration_q <= `CFG_RESET;
    end else begin
      if (le_rise) begin
        addr_q <= {up_q, adq_q};
      end
      if (state_q == S_PROGRAMMING) begin
        if (prog_cnt_q == {`PROG_CNT_W{1'b0}}) begin
          state_q <= S_READ;
          status_q[`STAT_READY] <= 1'b1;
          status_q[`STAT_SUSP] <= 1'b0;
        end else begin
          prog_cnt_q <= prog_cnt_q - 1'b1;
        end
      end
      if (wr_stb) begin
        case (state_q)
          S_READ: begin
            case (code)
              `CMD_SETUP: state_q <= S_SETUP;
              `CMD_PROGRAM: state_q <= S_PROG_DATA;
              `CMD_OTP_PROGRAM: state_q <= S_OTP_DATA;
              `CMD_STATUS_READ: rmode_q <= RM_STATUS;
              `CMD_SIGNATURE_READ: rmode_q <= RM_SIG;
              `CMD_QUERY_READ: rmode_q <= RM_SIG;
              `CMD_CLEAR_STATUS: status_q <= status_q & 8'hc5;
              default: rmode_q <= RM_ARRAY;
            endcase
          end
          S_SETUP: begin
            state_q <= S_READ;
            rmode_q <= RM_STATUS;
            if (code == `CMD_CFG_CONFIRM) begin
              // register takes the latched address bits, not the data
              read_configuration_q <= addr_q[15:0];
              rmode_q <= RM_ARRAY;
            end else if (!guard_we) begin
              status_q[`STAT_ERASE_ERR] <= 1'b1;
              status_q[`STAT_PROG_ERR] <= 1'b1;
            end
          end
          S_PROG_DATA: begin
            rmode_q <= RM_STATUS;
            if (prog_refused) begin
              status_q[`STAT_GUARD_ERR] <= 1'b1;
              state_q <= S_READ;
            end else begin
              state_q <= S_PROGRAMMING;
              prog_bank_q <= addr_q[`BANK_BIT];
              prog_cnt_q <= PROG_LOAD;
              status_q[`STAT_READY] <= 1'b0;
            end
          end
          S_PROGRAMMING: begin
            // suspend only inside the bank being programmed
            if (code == `CMD_SUSPEND && in_prog_bank) begin
              state_q <= S_SUSPENDED;
              status_q[`STAT_SUSP] <= 1'b1;
              status_q[`STAT_READY] <= 1'b1;
            end else if (code == `CMD_STATUS_READ) begin
              rmode_q <= RM_STATUS;
            end
          end
          S_SUSPENDED: begin
            case (code)
              `CMD_RESUME: begin
                if (in_prog_bank) begin
                  state_q <= S_PROGRAMMING;
                  status_q[`STAT_SUSP] <= 1'b0;
                  status_q[`STAT_READY] <= 1'b0;
                  rmode_q <= RM_STATUS;
                end
              end
              `CMD_READ_ARRAY: rmode_q <= RM_ARRAY;
              `CMD_STATUS_READ: rmode_q <= RM_STATUS;
              `CMD_SIGNATURE_READ: rmode_q <= RM_SIG;
              `CMD_QUERY_READ: rmode_q <= RM_SIG;
              default: rmode_q <= rmode_q; // others ignored
            endcase
          end
          S_OTP_DATA: begin
            state_q <= S_READ;
            rmode_q <= RM_STATUS;
            // bits only go to zero; lock bit1 freezes otp and bit2
            if (pr_addr == `PR_LOCK_ADDR) begin
              lock_word_q[`PR_LOCK_OTP_BIT] <= lock_word_q[`PR_LOCK_OTP_BIT] & wdata[`PR_LOCK_OTP_BIT];
              if (lock_word_q[`PR_LOCK_OTP_BIT]) begin
                lock_word_q[`PR_LOCK_SEC_BIT] <= lock_word_q[`PR_LOCK_SEC_BIT] & wdata[`PR_LOCK_SEC_BIT];
              end
            end else if (pr_is_otp && lock_word_q[`PR_LOCK_OTP_BIT]) begin
              otp_q[pr_word*16 +: 16] <= otp_q[pr_word*16 +: 16] & wdata;
            end else begin
              status_q[`STAT_GUARD_ERR] <= 1'b1;
            end
          end
          default: state_q <= S_READ;
        endcase
      end
    end
  end

  // ==========================================
  // read path and config decode
  wire [3:0] uid_sel = {2'b00, pr_word};
  reg [15:0] rd_d;
  always @* begin
    rd_d = 16'h0000;
    case (rmode_q)
      RM_STATUS: rd_d = {8'h00, status_q};
      RM_SIG: begin
        if (pr_addr == `SIG_PROT_LOC) begin
          rd_d = {14'h0000, blk_lock, blk_prot};
        end else if (pr_addr == `SIG_CFG_LOC) begin
          rd_d = read_configuration_q;
        end else if (pr_addr == `PR_LOCK_ADDR) begin
          rd_d = lock_word_q;
        end else if (pr_addr >= `PR_UID_FIRST && pr_addr <= `PR_UID_LAST) begin
          rd_d = UNIQUE_ID[uid_sel*16 +: 16];
        end else if (pr_is_otp) begin
          rd_d = otp_q[pr_word*16 +: 16];
        end
      end
      default: rd_d = 16'h0000; // array data lives outside this block
    endcase
  end

  wire [2:0] lat = read_configuration_q[`CFG_LAT_HI:`CFG_LAT_LO];
  wire [2:0] len = read_configuration_q[`CFG_LEN_HI:`CFG_LEN_LO];
  wire burst_mode = !read_configuration_q[`CFG_MODE_BIT];
  wire linear = read_configuration_q[`CFG_ORDER_BIT];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data_q <= 16'h0000;
      bus_invert_out_q <= 1'b0;
      bus_invert_oe_q <= 1'b0;
      latency_q <= 2'd0;
      latency_bad_q <= 1'b1;
      length_bad_q <= 1'b0;
      sec_block_prot_q <= 1'b0;
      page_word_q <= 2'd0;
    end else begin
      read_data_q <= rd_d;
      bus_invert_oe_q <= inv_active && burst_mode;
      bus_invert_out_q <= inv_active && burst_mode && (rd_d[15:8] == 8'hff);
      latency_q <= lat[1:0] - 2'd2;
      latency_bad_q <= (lat < `LAT_MIN) || (lat > `LAT_MAX);
      // continuous burst only legal in linear order
      length_bad_q <= !((len == `LEN_4) || (len == `LEN_8) || (len == `LEN_CONT && linear));
      sec_block_prot_q <= !lock_word_q[`PR_LOCK_SEC_BIT];
      if (!burst_mode) begin
        // word select follows the latched address, not the data phase
        page_word_q <= addr_q[1:0];
      end
    end
  end

endmodule
`default_nettype wire

// *** flash_cmd_if_asserts.sv ***
// port checker for the flash command interface
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.vh"
module flash_cmd_if_asserts (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic reset_powerdown_n, // pin reset
  input wire logic [15:0] read_configuration_q, // config
  input wire logic [7:0] status_q, // status
  input wire logic latency_bad_q, // latency reserved
  input wire logic length_bad_q, // length invalid
  input wire logic bus_invert_oe_q, // invert drive
  input wire logic sec_block_prot_q // security lock
);
  // ====
  // clocking and helpers
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire [15:0] c = read_configuration_q;
  // decoded fields may lag a config write by a cycle
  sequence settled;
    $stable(c) [*2];
  endsequence
  // ====
  // assertions
  a_cfg_reset: assert property ($rose(rst_n) |-> c == `CFG_RESET && status_q == 8'h80)
    else $error("reset value wrong");
  a_invert_dir: assert property (settled |-> bus_invert_oe_q == (c[14] && !c[15]))
    else $error("invert drive wrong");
  a_latency_code: assert property (settled |-> latency_bad_q == (c[13:11] < 3'h2 || c[13:11] > 3'h5))
    else $error("latency flag wrong");
  a_length_code: assert property (settled |->
    length_bad_q != (c[2:0] == 3'h1 || c[2:0] == 3'h2 || (c[2:0] == 3'h7 && c[7])))
    else $error("length flag wrong");
  a_seq_pair: assert property ($rose(status_q[5]) |-> status_q[4])
    else $error("sequence error bits split");
  a_suspend_busy: assert property ($rose(status_q[2]) |-> !$past(status_q[7]))
    else $error("suspend flag without program");
  a_resume_clear: assert property ($fell(status_q[2]) && reset_powerdown_n |-> !status_q[7])
    else $error("resume left ready set");
  a_sec_sticky: assert property (sec_block_prot_q |=> sec_block_prot_q)
    else $error("security lock dropped");
  cover property ($rose(status_q[2]));
  cover property (settled ##0 bus_invert_oe_q);
  cover property ($rose(sec_block_prot_q));
endmodule
bind flash_cmd_if flash_cmd_if_asserts flash_cmd_if_asserts_i (
  .clk(clk),
  .rst_n(rst_n),
  .reset_powerdown_n(reset_powerdown_n),
  .read_configuration_q(read_configuration_q),
  .status_q(status_q),
  .latency_bad_q(latency_bad_q),
  .length_bad_q(length_bad_q),
  .bus_invert_oe_q(bus_invert_oe_q),
  .sec_block_prot_q(sec_block_prot_q)
);
`default_nettype wire

// *** flash_host.sv ***
// host model driving the command bus pins
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  input wire logic clk, // clock
  output logic latch_n, // latch enable
  output logic write_n, // write enable
  output logic [15:0] mux_addr_data, // address/data
  output logic [5:0] upper_addr // upper address
);
  initial begin
    latch_n = 1'b1;
    write_n = 1'b1;
    mux_addr_data = 16'h0;
    upper_addr = 6'h0;
  end
  // ====
  // bus cycles: each phase 4 clocks, so a strobe cycle lasts 200 ns
  task automatic phase(input logic [15:0] v);
    mux_addr_data = v;
    repeat (4) @(negedge clk);
  endtask
  task automatic latch(input logic [21:0] a);
    @(negedge clk);
    upper_addr = a[21:16];
    latch_n = 1'b0;
    phase(a[15:0]);
    latch_n = 1'b1;
    phase(a[15:0]);
    // released bus shows a changed pattern, never the old value
    mux_addr_data = ~a[15:0];
  endtask
  task automatic write(input logic [21:0] a, input logic [15:0] d);
    latch(a);
    write_n = 1'b0;
    phase(d);
    write_n = 1'b1;
    phase(d);
    mux_addr_data = ~d;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the flash command interface
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defines.vh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_n = 1'b1;
  logic wp_n = 1'b1;
  logic inv_in = 1'b0;
  wire latch_n, write_n, inv_out, oe, lat_bad, len_bad, sec;
  wire [15:0] mux, rdata, cfg;
  wire [7:0] stat;
  wire [5:0] ua;
  wire [1:0] lat, pw;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  typedef struct {int s; logic [15:0] v;} note_t;
  note_t notes[$];
  always #12.5 clk = ~clk;
  flash_host flash_host_i (.clk(clk), .latch_n(latch_n), .write_n(write_n), .mux_addr_data(mux), .upper_addr(ua));
  flash_cmd_if flash_cmd_if_i (.clk(clk), .rst_n(rst_n), .reset_powerdown_n(pin_n), .wp_n(wp_n),
    .latch_n(latch_n), .write_n(write_n), .mux_addr_data(mux), .upper_addr(ua), .bus_invert_in(inv_in),
    .read_data_q(rdata), .bus_invert_out_q(inv_out), .bus_invert_oe_q(oe), .read_configuration_q(cfg),
    .status_q(stat), .latency_q(lat), .latency_bad_q(lat_bad), .length_bad_q(len_bad),
    .sec_block_prot_q(sec), .page_word_q(pw));
  // ====
  // checking
  task automatic compare(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    #1;
    while (notes.size() > 0) begin
      note_t n;
      n = notes.pop_front();
      compare(n.s == 0 ? rdata : n.s == 1 ? {8'h0, stat} : n.s == 2 ? cfg :
        n.s == 3 ? {11'h0, inv_out, lat_bad, len_bad, oe, sec} :
        n.s == 4 ? {14'h0, lat} : {14'h0, pw}, n.v);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ====
  // stimulus helpers
  task automatic expect_v(input int s, input logic [15:0] v);
    notes.push_back('{s, v});
    @(negedge clk);
  endtask
  task automatic cmd(input logic [21:0] a, input logic [7:0] c);
    flash_host_i.write(a, {8'h0, c});
  endtask
  task automatic rd_at(input logic [21:0] a, input logic [15:0] v);
    flash_host_i.latch(a);
    repeat (4) @(negedge clk);
    expect_v(0, v);
  endtask
  task automatic look(input logic [5:0] k, input logic [15:0] v);
    cmd({k, 16'h0}, `CMD_SIGNATURE_READ);
    rd_at({k, 8'h0, `SIG_PROT_LOC}, v);
  endtask
  task automatic prot(input logic [5:0] k, input logic [7:0] c, input logic [15:0] v);
    cmd({k, 16'h0}, `CMD_SETUP);
    cmd({k, 16'h0}, c);
    look(k, v);
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 1000 && stat[7] !== 1'b1; n++) @(negedge clk);
  endtask
  task automatic prog(input logic [21:0] a, input logic [7:0] c, input logic [15:0] d);
    cmd(a, c);
    flash_host_i.write(a, d);
    wait_ready();
  endtask
  task automatic otp(input logic [7:0] a, input logic [15:0] d, input logic [15:0] v);
    prog({14'h0, a}, `CMD_OTP_PROGRAM, d);
    cmd(22'h0, `CMD_SIGNATURE_READ);
    rd_at({14'h0, a}, v);
  endtask
  // ====
  // main sequence
  initial begin
    logic [5:0] b, bn, u;
    logic [15:0] d, cv;
    logic [2:0] ln;
    d = 16'($urandom(32'h03f75e9a));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    expect_v(2, `CFG_RESET);
    expect_v(3, 16'h0008);
    b = 6'($urandom_range(61, 2));
    bn = b ^ 6'h01;
    look(b, 16'h0001);
    prot(b, `CMD_UNGUARD, 16'h0000);
    prot(b, `CMD_GUARD, 16'h0001);
    prot(b, `CMD_FREEZE, 16'h0003);
    prot(b, `CMD_UNGUARD, 16'h0002);
    wp_n = 1'b0;
    look(b, 16'h0003);
    prot(b, `CMD_UNGUARD, 16'h0003);
    prot(bn, `CMD_UNGUARD, 16'h0000);
    wp_n = 1'b1;
    look(b, 16'h0002);
    d[7:0] = 8'($urandom_range(254, 4));
    if (d[7:0] == `CMD_UNGUARD || d[7:0] == `CMD_FREEZE) d[7:0] = 8'h11;
    cmd({b, 16'h0}, `CMD_SETUP);
    cmd({b, 16'h0}, d[7:0]);
    expect_v(1, 16'h00b0);
    cmd({b, 16'h0}, `CMD_CLEAR_STATUS);
    for (int i = 0; i < 8; i++) begin
      ln = i[1:0] == 2'h0 ? `LEN_4 : i[1:0] == 2'h1 ? `LEN_8 : i[1:0] == 2'h2 ? `LEN_CONT : 3'h4;
      cv = {i[0], i[1], i[2:0], 2'h0, i[1], i[2], !i[0], 2'h0, i[0], ln};
      u = 6'($urandom);
      cmd({u, cv}, `CMD_SETUP);
      cmd({u, cv}, `CMD_CFG_CONFIRM);
      expect_v(2, cv);
      expect_v(3, {12'h0, i < 2 || i > 5, !(ln == `LEN_4 || ln == `LEN_8 || (ln == `LEN_CONT && i[2])),
        i[1] && !i[0], 1'b0});
      if (i >= 2 && i <= 5) expect_v(4, 16'(i - 2));
    end
    // invert enabled by the last config: inverted status read must decode
    inv_in = 1'b1;
    flash_host_i.write({bn, 16'h0}, ~{8'h0, `CMD_STATUS_READ});
    inv_in = 1'b0;
    expect_v(0, 16'h0080);
    cmd({bn, 16'h0}, `CMD_SUSPEND);
    expect_v(1, 16'h0080);
    for (int k = 0; k < 2; k++) begin
      cmd({bn, 16'h0}, `CMD_PROGRAM);
      flash_host_i.write({bn, 15'h0010, k[0]}, 16'($urandom));
      expect_v(1, 16'h0000);
      cmd({bn, 16'h0}, `CMD_SUSPEND);
      repeat (8) @(negedge clk);
      expect_v(1, 16'h0084);
      if (k == 0) begin
        prot(bn, `CMD_GUARD, 16'h0000);
        expect_v(1, 16'h0084);
        cmd({bn, 16'h0}, `CMD_RESUME);
        expect_v(1, 16'h0000);
        rd_at({bn, 16'h0}, 16'h0000);
        repeat (450) @(negedge clk);
        expect_v(1, 16'h0080);
      end else begin
        pin_n = 1'b0;
        repeat (20) @(negedge clk);
        pin_n = 1'b1;
        repeat (6) @(negedge clk);
        expect_v(1, 16'h0080);
        expect_v(2, `CFG_RESET);
      end
    end
    // security block still open: unprotected program must start
    cmd(22'h3f0000, `CMD_SETUP);
    cmd(22'h3f0000, `CMD_UNGUARD);
    prog(22'h3f0000, `CMD_PROGRAM, 16'h0);
    expect_v(1, 16'h0080);
    prog(22'h010000, `CMD_PROGRAM, 16'h0);
    expect_v(1, 16'h0082);
    cmd(22'h0, `CMD_SIGNATURE_READ);
    rd_at({14'h0, `PR_LOCK_ADDR}, 16'hffff);
    otp(`PR_OTP_FIRST, d, d);
    expect_v(5, 16'h0001);
    otp(`PR_LOCK_ADDR, 16'hfffb, 16'hfffb);
    expect_v(3, 16'h0009);
    otp(`PR_LOCK_ADDR, 16'hfffd, 16'hfff9);
    otp(`PR_OTP_LAST, 16'h0, 16'hffff);
    cmd(22'h3f0000, `CMD_CLEAR_STATUS);
    cmd(22'h3f0000, `CMD_SETUP);
    cmd(22'h3f0000, `CMD_UNGUARD);
    prog(22'h3f0000, `CMD_PROGRAM, 16'h0);
    expect_v(1, 16'h0082);
    close_out();
  end
endmodule
`default_nettype wire
